/* src/capsns_top.sv */
// capsns_top: capacitive sensing oscillator control, timer clock routing and APB registers
`timescale 1ns/1ps
module capsns_top
    import capsns_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          sense_osc_in,
    input  wire logic          timer0_pin_in,
    input  wire logic          instr_clk_en,
    input  wire logic          timer1_other_clk_en,
    input  wire logic          timer1_gate_in,
    input  wire logic          sleep_mode,
    output capsns_analog_s     analog_ctrl,
    output logic               timer0_overflow,
    output logic               timer1_overflow
);
    // ==========================================================
    // registers
    logic [7:0]          control;
    logic [7:0]          timer_cfg;
    logic [T0_WIDTH-1:0] timer0_value;
    logic [T1_WIDTH-1:0] timer1_value;
    logic                osc_sync;
    logic                osc_rise;
    logic                pin_sync;
    logic                pin_rise;
    logic                t0_count;
    logic                t1_count;
    logic                t0_ovf;
    logic                t1_ovf;
    logic                t0_load;
    logic                t1_load;
    logic                apb_write;
    logic                apb_read;
    logic                mapped;
    capsns_analog_s      next_analog;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
        addr_hit = (a == ofs);
    endfunction : addr_hit

    function automatic capsns_cur_e decode_range(input logic refm, input logic [1:0] rng);
        case (rng)
            2'h0:    decode_range = refm ? CAPSNS_CUR_NOISE : CAPSNS_CUR_OFF;
            2'h1:    decode_range = CAPSNS_CUR_LOW;
            2'h2:    decode_range = CAPSNS_CUR_MED;
            2'h3:    decode_range = CAPSNS_CUR_HIGH;
            default: decode_range = CAPSNS_CUR_OFF;
        endcase
    endfunction : decode_range

    // ==========================================================
    // apb access decode
    assign apb_write = psel & penable & pwrite;
    assign apb_read  = psel & ~penable & ~pwrite;
    assign mapped    = addr_hit(paddr, CAPSNS_OFS_CONTROL)   |
                       addr_hit(paddr, CAPSNS_OFS_TIMER_CFG) |
                       addr_hit(paddr, CAPSNS_OFS_TIMER0)    |
                       addr_hit(paddr, CAPSNS_OFS_TIMER1);

    // ==========================================================
    // oscillator and timer0 pin synchronisers
    capsns_sync u_osc_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (sense_osc_in),
        .sync_out (osc_sync),
        .rise     (osc_rise)
    );

    capsns_sync u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (timer0_pin_in),
        .sync_out (pin_sync),
        .rise     (pin_rise)
    );

    // ==========================================================
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= CTL_RESET_VALUE;
        end else if (apb_write && addr_hit(paddr, CAPSNS_OFS_CONTROL) && pstrb[0]) begin
            control <= (pwdata[7:0] & CTL_WRITE_MASK) | {6'h00, osc_sync, 1'b0} &
                       ~CTL_WRITE_MASK;
        end else begin
            control[CTL_STATUS_BIT] <= osc_sync;
        end
    end

    // ==========================================================
    // timer configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_cfg <= TCF_RESET_VALUE;
        end else if (apb_write && addr_hit(paddr, CAPSNS_OFS_TIMER_CFG) && pstrb[0]) begin
            timer_cfg <= pwdata[7:0] & TCF_WRITE_MASK;
        end
    end

    // ==========================================================
    // analog control outputs
    always_comb begin
        next_analog.osc_enable    = control[CTL_ENABLE_BIT];
        next_analog.variable_ref  = control[CTL_REFMODE_BIT];
        next_analog.current       = control[CTL_ENABLE_BIT] ?
            decode_range(control[CTL_REFMODE_BIT],
                         control[CTL_RANGE_HI:CTL_RANGE_LO]) : CAPSNS_CUR_OFF;
        next_analog.source_enable = control[CTL_ENABLE_BIT] &&
                                    (control[CTL_RANGE_HI:CTL_RANGE_LO] != 2'h0);
        if (control[CTL_ENABLE_BIT] && !control[CTL_REFMODE_BIT] &&
            control[CTL_RANGE_HI:CTL_RANGE_LO] == 2'h0) begin
            next_analog.osc_enable = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl <= next_analog;
        end
    end

    // ==========================================================
    // timer clock routing
    always_comb begin
        if (!timer_cfg[TCF_T0CS_BIT]) begin
            t0_count = instr_clk_en;
        end else if (control[CTL_T0XSEL_BIT]) begin
            t0_count = osc_rise;
        end else begin
            t0_count = pin_rise;
        end
        if (sleep_mode) begin
            t0_count = 1'b0;
        end
    end

    always_comb begin
        if (!timer_cfg[TCF_T1ON_BIT]) begin
            t1_count = 1'b0;
        end else if (timer_cfg[TCF_T1GE_BIT] && !timer1_gate_in) begin
            t1_count = 1'b0;
        end else if (timer_cfg[TCF_T1CS_HI:TCF_T1CS_LO] == T1CS_SENSE_OSC) begin
            t1_count = osc_rise;
        end else begin
            t1_count = timer1_other_clk_en;
        end
    end

    assign t0_load = apb_write && addr_hit(paddr, CAPSNS_OFS_TIMER0) && pstrb[0];
    assign t1_load = apb_write && addr_hit(paddr, CAPSNS_OFS_TIMER1) && (|pstrb[1:0]);

    capsns_counter #(.WIDTH(T0_WIDTH)) u_timer0 (
        .pclk       (pclk),
        .presetn    (presetn),
        .count_en   (t0_count),
        .load       (t0_load),
        .load_value (pwdata[T0_WIDTH-1:0]),
        .value      (timer0_value),
        .overflow   (t0_ovf)
    );

    capsns_counter #(.WIDTH(T1_WIDTH)) u_timer1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .count_en   (t1_count),
        .load       (t1_load),
        .load_value (pwdata[T1_WIDTH-1:0]),
        .value      (timer1_value),
        .overflow   (t1_ovf)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
        end else begin
            timer0_overflow <= t0_ovf;
            timer1_overflow <= t1_ovf;
        end
    end

    // ==========================================================
    // apb read path: data latched in setup, answered in one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_read) begin
            if (addr_hit(paddr, CAPSNS_OFS_CONTROL)) begin
                prdata <= {24'h000000, control};
            end else if (addr_hit(paddr, CAPSNS_OFS_TIMER_CFG)) begin
                prdata <= {24'h000000, timer_cfg};
            end else if (addr_hit(paddr, CAPSNS_OFS_TIMER0)) begin
                prdata <= {24'h000000, timer0_value};
            end else if (addr_hit(paddr, CAPSNS_OFS_TIMER1)) begin
                prdata <= {16'h0000, timer1_value};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // ==========================================================
    // checks
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        control[5:4] == 2'h0 && control[CTL_STATUS_BIT] == $past(osc_sync))
        else $error("reserved bits or status mismatch");

    chk_noise_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (control[7:6] == 2'h3 && control[3:2] == 2'h0) |=> analog_ctrl.current ==
        CAPSNS_CUR_NOISE && !analog_ctrl.source_enable && analog_ctrl.osc_enable)
        else $error("noise detection decode wrong");

    chk_fixed_off: assert property (@(posedge pclk) disable iff (!presetn)
        (control[7:6] == 2'h2 && control[3:2] == 2'h0) |=> !analog_ctrl.osc_enable)
        else $error("fixed mode off not honoured");

    chk_disable_off: assert property (@(posedge pclk) disable iff (!presetn)
        !control[7] |=> !analog_ctrl.osc_enable && analog_ctrl.current == CAPSNS_CUR_OFF)
        else $error("module disabled but oscillator on");

    chk_refmode_out: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctrl.variable_ref == $past(control[6]))
        else $error("reference mode not routed");

    chk_t0_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_mode && !t0_load) |=> timer0_value == $past(timer0_value))
        else $error("timer0 counted in sleep");

    chk_t0_osc: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_cfg[0] && control[0] && !sleep_mode && osc_rise && !t0_load)
        |=> timer0_value == $past(timer0_value) + 8'h01)
        else $error("timer0 missed oscillator edge");

    chk_t1_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!timer_cfg[3] && !t1_load) |=> timer1_value == $past(timer1_value))
        else $error("timer1 counted while off");

    chk_t1_osc: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_cfg[4:1] == 4'h7 && osc_rise && !t1_load)
        |=> timer1_value == $past(timer1_value) + 16'h0001)
        else $error("timer1 missed oscillator edge");

    chk_pready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no answer after setup cycle");

    chk_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("answer held longer than one cycle");

    chk_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without answer");

    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped) |=> pslverr)
        else $error("unmapped access not flagged");

    chk_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_write && addr_hit(paddr, CAPSNS_OFS_TIMER_CFG) && pstrb[0])
        |=> timer_cfg == ($past(pwdata[7:0]) & TCF_WRITE_MASK))
        else $error("timer configuration write lost");

    chk_t0_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_cfg[0] && !control[0] && !sleep_mode && pin_rise && !t0_load)
        |=> timer0_value == $past(timer0_value) + 8'h01)
        else $error("timer0 missed pin edge");

    chk_t0_instr: assert property (@(posedge pclk) disable iff (!presetn)
        (!timer_cfg[0] && !sleep_mode && instr_clk_en && !t0_load)
        |=> timer0_value == $past(timer0_value) + 8'h01)
        else $error("timer0 missed instruction clock");

    chk_t1_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_cfg[4:3] == 2'h3 && !timer1_gate_in && !t1_load)
        |=> timer1_value == $past(timer1_value))
        else $error("timer1 counted with gate shut");

    chk_t1_free: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_cfg[4:1] == 4'h4 && timer1_other_clk_en && !t1_load)
        |=> timer1_value == $past(timer1_value) + 16'h0001)
        else $error("timer1 missed other clock");

    chk_t0_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (t0_count && timer0_value == 8'hFF && !t0_load) |=> ##1 timer0_overflow)
        else $error("timer0 wrap without overflow pulse");

    chk_t1_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (t1_count && timer1_value == 16'hFFFF && !t1_load) |=> ##1 timer1_overflow)
        else $error("timer1 wrap without overflow pulse");

    chk_source_osc: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctrl.source_enable |-> analog_ctrl.osc_enable)
        else $error("current source on with oscillator off");

    chk_range_low: assert property (@(posedge pclk) disable iff (!presetn)
        (control[7] && control[3:2] == 2'h1) |=> analog_ctrl.current == CAPSNS_CUR_LOW &&
        analog_ctrl.source_enable)
        else $error("low range decode wrong");

    chk_osc_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        (control[7] && control[3:2] != 2'h0) |=> analog_ctrl.osc_enable)
        else $error("oscillator stopped while enabled");

endmodule : capsns_top

/* src/capsns_pkg.sv */
// capsns_pkg: register map, field layout, reset values and shared types of the sensing block
package capsns_pkg;

    // ==========================================================
    // register map (APB byte addresses)
    localparam logic [11:0] CAPSNS_OFS_CONTROL   = 12'h000;
    localparam logic [11:0] CAPSNS_OFS_TIMER_CFG = 12'h004;
    localparam logic [11:0] CAPSNS_OFS_TIMER0    = 12'h008;
    localparam logic [11:0] CAPSNS_OFS_TIMER1    = 12'h00C;

    // ==========================================================
    // control register fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_REFMODE_BIT = 6;
    localparam int CTL_RANGE_HI   = 3;
    localparam int CTL_RANGE_LO   = 2;
    localparam int CTL_STATUS_BIT = 1;
    localparam int CTL_T0XSEL_BIT = 0;
    localparam logic [7:0] CTL_WRITE_MASK  = 8'hCD;
    localparam logic [7:0] CTL_RESET_VALUE = 8'h00;

    // ==========================================================
    // timer configuration register fields
    localparam int TCF_T0CS_BIT   = 0;
    localparam int TCF_T1CS_LO    = 1;
    localparam int TCF_T1CS_HI    = 2;
    localparam int TCF_T1ON_BIT   = 3;
    localparam int TCF_T1GE_BIT   = 4;
    localparam logic [7:0] TCF_WRITE_MASK  = 8'h1F;
    localparam logic [7:0] TCF_RESET_VALUE = 8'h00;
    localparam logic [1:0] T1CS_SENSE_OSC  = 2'h3;

    // ==========================================================
    // timer widths and reset values
    localparam int T0_WIDTH = 8;
    localparam int T1_WIDTH = 16;
    localparam logic [T0_WIDTH-1:0] T0_RESET_VALUE = 8'h00;
    localparam logic [T1_WIDTH-1:0] T1_RESET_VALUE = 16'h0000;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        CAPSNS_CUR_OFF   = 3'h0,
        CAPSNS_CUR_LOW   = 3'h1,
        CAPSNS_CUR_MED   = 3'h3,
        CAPSNS_CUR_HIGH  = 3'h2,
        CAPSNS_CUR_NOISE = 3'h6
    } capsns_cur_e;

    typedef struct packed {
        logic        osc_enable;
        logic        variable_ref;
        logic        source_enable;
        capsns_cur_e current;
    } capsns_analog_s;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } capsns_apb_req_s;

endpackage : capsns_pkg

/* src/capsns_sync.sv */
// capsns_sync: two-flop synchroniser with edge detect on the second stage
`timescale 1ns/1ps
module capsns_sync
    import capsns_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out,
    output logic      rise
);
    logic meta;
    logic prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
            prev     <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
            prev     <= sync_out;
        end
    end

    assign rise = sync_out & ~prev;
endmodule : capsns_sync

/* src/capsns_counter.sv */
// capsns_counter: clearable, loadable event counter with overflow pulse
`timescale 1ns/1ps
module capsns_counter
    import capsns_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             count_en,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] value,
    output logic                  overflow
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value    <= '0;
            overflow <= 1'b0;
        end else if (load) begin
            value    <= load_value;
            overflow <= 1'b0;
        end else begin
            overflow <= count_en & (&value);
            if (count_en) begin
                value <= value + 1'b1;
            end
        end
    end
endmodule : capsns_counter

/* bench/capsns_pad_model.sv */
// capsns_pad_model: behavioural sensing pad with its relaxation oscillator
`timescale 1ns/1ps
module capsns_pad_model
    import capsns_pkg::*;
#(
    parameter int FAST_NS = 40,
    parameter int SLOW_NS = 2000
) (
    input  wire capsns_analog_s analog_ctrl,
    input  wire logic           slow,
    output logic                sense_osc_in
);
    // ==========================================================
    // oscillator, no sleep input: it runs on while the part sleeps
    initial sense_osc_in = 1'b0;
    always begin
        if (slow) #(SLOW_NS);
        else #(FAST_NS);
        if (!analog_ctrl.osc_enable) begin
            sense_osc_in = 1'b0;
        end else if (analog_ctrl.source_enable) begin
            sense_osc_in = ~sense_osc_in;
        end
    end
endmodule : capsns_pad_model

/* bench/testbench.sv */
// testbench: self-checking bench of the capacitive sensing control block
`timescale 1ns/1ps
module testbench
    import capsns_pkg::*;
;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic           sense_osc_in, timer0_pin_in, instr_clk_en, timer1_other_clk_en;
    logic           timer1_gate_in, sleep_mode, timer0_overflow, timer1_overflow;
    logic [3:0]     pstrb;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd, t0, t1;
    capsns_analog_s analog_ctrl;
    int             n_errors, compares, osc_edges, ovf0, n;

    capsns_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense_osc_in(sense_osc_in), .timer0_pin_in(timer0_pin_in),
        .instr_clk_en(instr_clk_en), .timer1_other_clk_en(timer1_other_clk_en),
        .timer1_gate_in(timer1_gate_in), .sleep_mode(sleep_mode),
        .analog_ctrl(analog_ctrl), .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow));
    capsns_pad_model u_pad (.analog_ctrl(analog_ctrl), .slow(slow),
        .sense_osc_in(sense_osc_in));

    // ==========================================================
    // clock and monitors
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge sense_osc_in) osc_edges++;
    always @(posedge pclk) begin
        if (timer0_overflow === 1'b1) ovf0++;
    end

    // ==========================================================
    // helpers
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task pulses(input int k, input logic pin);
        repeat (k) begin
            timer0_pin_in <= pin;
            instr_clk_en <= !pin;
            timer1_other_clk_en <= !pin;
            @(posedge pclk);
            instr_clk_en <= 1'b0;
            timer1_other_clk_en <= 1'b0;
            repeat (3) @(posedge pclk);
            timer0_pin_in <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask : pulses
    // clears both timers while the pad runs slow, then lets it run fast for a fixed span
    task measure();
        slow <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(CAPSNS_OFS_TIMER0, 1'b1, 32'h0);
        apb(CAPSNS_OFS_TIMER1, 1'b1, 32'h0);
        osc_edges = 0;
        slow <= 1'b0;
        repeat (1000) @(posedge pclk);
        slow <= 1'b1;
        repeat (20) @(posedge pclk);
        n = osc_edges;
        apb(CAPSNS_OFS_TIMER0, 1'b0, 32'h0);
        t0 = rd;
        apb(CAPSNS_OFS_TIMER1, 1'b0, 32'h0);
        t1 = rd;
    endtask : measure

    // ==========================================================
    // scenarios
    task t_regs();
        chk("analog reset", 32'h0, {26'h0, analog_ctrl});
        for (int i = 0; i < 4; i++) begin
            apb(12'(i * 4), 1'b0, 32'h0);
            chk("register reset", 32'h0, rd);
        end
        apb(CAPSNS_OFS_CONTROL, 1'b1, 32'hFFFF_FFFF);
        apb(CAPSNS_OFS_CONTROL, 1'b0, 32'h0);
        chk("control rw", 32'hCD, rd & 32'hFFFF_FFFD);
        apb(12'h010, 1'b1, 32'h0);
        chk("unmapped write err", 32'h1, {31'h0, err});
        apb(12'h010, 1'b0, 32'h0);
        chk("unmapped read err", 32'h1, {31'h0, err});
        chk("unmapped read data", 32'h0, rd);
        apb(CAPSNS_OFS_CONTROL, 1'b0, 32'h0);
        chk("control kept", 32'hCD, rd & 32'hFFFF_FFFD);
    endtask : t_regs
    task t_decode();
        capsns_cur_e cur;
        for (int i = 0; i < 8; i++) begin
            case (i[1:0])
                2'h0: cur = i[2] ? CAPSNS_CUR_NOISE : CAPSNS_CUR_OFF;
                2'h1: cur = CAPSNS_CUR_LOW;
                2'h2: cur = CAPSNS_CUR_MED;
                default: cur = CAPSNS_CUR_HIGH;
            endcase
            apb(CAPSNS_OFS_CONTROL, 1'b1, {24'h0, 1'b1, i[2], 2'h0, i[1:0], 2'h0});
            repeat (3) @(posedge pclk);
            chk("analog", {26'h0, i != 0, i[2], |i[1:0], cur}, {26'h0, analog_ctrl});
        end
        apb(CAPSNS_OFS_CONTROL, 1'b1, 32'h4C);
        repeat (3) @(posedge pclk);
        chk("osc off", 32'h0, {31'h0, analog_ctrl.osc_enable});
    endtask : t_decode
    task t_status();
        apb(CAPSNS_OFS_CONTROL, 1'b1, 32'h8C);
        slow <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(sense_osc_in);
            repeat (10) @(posedge pclk);
            apb(CAPSNS_OFS_CONTROL, 1'b0, 32'h0);
            chk("status", {31'h0, sense_osc_in}, {31'h0, rd[CTL_STATUS_BIT]});
        end
    endtask : t_status
    task t_osc();
        // the span is timed by the bench, not by the timer being counted
        apb(CAPSNS_OFS_CONTROL, 1'b1, 32'h8D);
        apb(CAPSNS_OFS_TIMER_CFG, 1'b1, 32'h0F);
        measure();
        chk("edges seen", 32'h1, {31'h0, n != 0});
        chk("timer0 osc", 32'(n & 255), t0);
        chk("timer1 osc", 32'(n), t1);
        sleep_mode <= 1'b1;
        measure();
        chk("timer0 sleep", 32'h0, t0);
        chk("timer1 sleep", 32'(n), t1);
        sleep_mode <= 1'b0;
        apb(CAPSNS_OFS_TIMER_CFG, 1'b1, 32'h1F);
        measure();
        chk("timer1 gate shut", 32'h0, t1);
        timer1_gate_in <= 1'b1;
        measure();
        chk("timer1 gate open", 32'(n), t1);
        apb(CAPSNS_OFS_TIMER_CFG, 1'b1, 32'h07);
        measure();
        chk("timer1 off", 32'h0, t1);
    endtask : t_osc
    task t_other();
        apb(CAPSNS_OFS_CONTROL, 1'b1, 32'h8C);
        apb(CAPSNS_OFS_TIMER_CFG, 1'b1, 32'h01);
        apb(CAPSNS_OFS_TIMER0, 1'b1, 32'hFE);
        ovf0 = 0;
        pulses(3, 1'b1);
        apb(CAPSNS_OFS_TIMER0, 1'b0, 32'h0);
        chk("timer0 pin", 32'h01, rd);
        chk("timer0 overflow", 32'h1, 32'(ovf0));
        apb(CAPSNS_OFS_TIMER_CFG, 1'b1, 32'h08);
        apb(CAPSNS_OFS_TIMER0, 1'b1, 32'h0);
        apb(CAPSNS_OFS_TIMER1, 1'b1, 32'h0);
        pulses(5, 1'b0);
        apb(CAPSNS_OFS_TIMER0, 1'b0, 32'h0);
        chk("timer0 instr", 32'h05, rd);
        apb(CAPSNS_OFS_TIMER1, 1'b0, 32'h0);
        chk("timer1 other", 32'h05, rd);
    endtask : t_other
    task finish_test();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // main sequence and watchdog
    initial begin
        {presetn, psel, penable, pwrite, slow, timer0_pin_in, instr_clk_en} = '0;
        {timer1_other_clk_en, timer1_gate_in, sleep_mode} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_decode();
        t_status();
        t_osc();
        t_other();
        finish_test();
    end
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
endmodule : testbench
